// ### design/ghp_device.sv
`timescale 1ns/10ps
module ghp_device (
   // Clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       reset_i,
   // Processor port
   ghp_if.dev              port,
   // Listener side, byte arriving from the instrument bus
   input  wire logic [7:0] rx_data_i,
   input  wire logic       rx_valid_i,
   output logic            rx_ready_o,
   // Talker side, byte leaving to the instrument bus
   output logic [7:0]      tx_data_o,
   output logic            tx_valid_o,
   input  wire logic       tx_ready_i,
   // Trigger condition from the bus logic
   input  wire logic       trigger_cond_i
);

   // ******************************************************
   // Declarations
   // ******************************************************
   logic [7:0] bus_in;
   logic [7:0] rd_value;
   logic [7:0] rd_flip;
   logic [7:0] status_reg;
   logic [7:0] status_next;
   logic [7:0] ctrl_reg;
   logic [7:0] mask_reg;
   logic [7:0] scr_reg [ghp_pkg::SCR_DEPTH];
   logic [7:0] din_reg;
   logic       din_full_reg;
   logic [7:0] dout_reg;
   logic       dout_full_reg;
   logic [7:0] rd_data_reg;
   logic [7:0] wdata_reg;
   logic [2:0] wsel_reg;
   logic       wr_act_reg;
   logic [2:0] rsel_reg;
   logic       rd_act_reg;
   logic       trig_reg;
   logic       trig_prev_reg;
   logic       irq_reg;
   logic       dmareq_reg;
   logic       any_rst;
   logic       granted;
   logic       rd_act;
   logic       wr_act;
   logic [2:0] rd_sel;
   logic       wr_commit;
   logic       rd_done;
   logic       wr_status;
   logic       wr_ctrl;
   logic       wr_mask;
   logic       wr_data;
   logic       wr_scr;
   logic [1:0] wscr_idx;
   logic [1:0] rscr_idx;
   logic       rx_take;
   logic       tx_take;
   logic       din_read;
   logic [7:0] set_bits;

   // ******************************************************
   // Bit order on the processor bus
   // ******************************************************
   // Bus line i carries register bit 7-i, so line 0 is the MSB
   for (genvar i = 0; i < ghp_pkg::DATA_W; i++) begin : g_flip
      assign bus_in[i]  = port.cpu_data_bus[7 - i];
      assign rd_flip[i] = rd_value[7 - i];
   end

   // ******************************************************
   // Access decode
   // ******************************************************
   // Chip reset pin shares the path of the system reset
   assign any_rst = reset_i | ~port.chip_reset_n;
   assign granted = ~port.dma_grant_n;
   // Normal read wants read strobe high, DMA read wants it low
   assign rd_act  = port.write_strobe_n &
                    ((~port.chip_select_n & port.read_strobe & ~granted) |
                     (granted & ~port.read_strobe));
   assign wr_act  = ~port.write_strobe_n & (~port.chip_select_n | granted);
   assign rd_sel  = granted ? ghp_pkg::SEL_DATA : port.reg_select;

   // Commit on the release of the write strobe
   assign wr_commit = wr_act_reg & ~wr_act;
   assign rd_done   = rd_act_reg & ~rd_act;
   assign wr_status = wr_commit & (wsel_reg == ghp_pkg::SEL_STATUS);
   assign wr_ctrl   = wr_commit & (wsel_reg == ghp_pkg::SEL_CTRL);
   assign wr_mask   = wr_commit & (wsel_reg == ghp_pkg::SEL_MASK);
   assign wr_data   = wr_commit & (wsel_reg == ghp_pkg::SEL_DATA);
   assign wr_scr    = wr_commit & (wsel_reg >= ghp_pkg::SEL_SCR_BASE) &
                      (wsel_reg != ghp_pkg::SEL_DATA);
   assign wscr_idx  = 2'(wsel_reg - ghp_pkg::SEL_SCR_BASE);
   assign rscr_idx  = 2'(rd_sel - ghp_pkg::SEL_SCR_BASE);
   assign din_read  = rd_done & (rsel_reg == ghp_pkg::SEL_DATA);

   // ******************************************************
   // Read selection
   // ******************************************************
   always_comb begin
      case (rd_sel)
         ghp_pkg::SEL_STATUS: rd_value = status_reg;
         ghp_pkg::SEL_CTRL:   rd_value = ctrl_reg;
         ghp_pkg::SEL_MASK:   rd_value = mask_reg;
         ghp_pkg::SEL_DATA:   rd_value = din_reg;
         default:             rd_value = scr_reg[rscr_idx];
      endcase
   end

   // ******************************************************
   // Listener and talker hand-off
   // ******************************************************
   assign rx_ready_o = ~din_full_reg;
   assign rx_take    = rx_valid_i & rx_ready_o;
   assign tx_valid_o = dout_full_reg;
   assign tx_take    = dout_full_reg & tx_ready_i;
   assign tx_data_o  = dout_reg;

   // ******************************************************
   // Sticky events, a set in the clear cycle wins
   // ******************************************************
   assign set_bits = {rx_take, tx_take, trig_reg & ~trig_prev_reg, 5'h00};
   assign status_next = (status_reg & ~(wr_status ? wdata_reg : 8'h00)) | set_bits;

   // ******************************************************
   // Pin outputs
   // ******************************************************
   // Interrupt is open drain, only its low level is ever driven
   assign port.irq_n_oe              = irq_reg;
   assign port.dma_request_n         = ~dmareq_reg;
   assign port.trigger_out           = trig_reg;
   assign port.in_charge_n           = ~ctrl_reg[ghp_pkg::CT_IN_CHARGE];
   assign port.transceiver_direction = ctrl_reg[ghp_pkg::CT_TALK];
   assign port.dev_data              = rd_data_reg;
   // Bus stays released unless a read is active
   assign port.dev_data_oe           = rd_act;

   // ******************************************************
   // Access capture
   // ******************************************************
   // Select and data sampled every strobe cycle, last one wins
   always_ff @(posedge ref_clk_i) begin
      if (any_rst) begin
         wr_act_reg  <= 1'b0;
         rd_act_reg  <= 1'b0;
         wsel_reg    <= 3'h0;
         rsel_reg    <= 3'h0;
         wdata_reg   <= ghp_pkg::DATA_RST;
         rd_data_reg <= ghp_pkg::DATA_RST;
      end else begin
         wr_act_reg  <= wr_act;
         rd_act_reg  <= rd_act;
         rsel_reg    <= rd_sel;
         rd_data_reg <= rd_flip;
         if (wr_act) begin
            wsel_reg  <= granted ? ghp_pkg::SEL_DATA : port.reg_select;
            wdata_reg <= bus_in;
         end
      end
   end

   // ******************************************************
   // Software registers
   // ******************************************************
   always_ff @(posedge ref_clk_i) begin
      if (any_rst) begin
         ctrl_reg   <= ghp_pkg::CTRL_RST;
         mask_reg   <= ghp_pkg::MASK_RST;
         status_reg <= ghp_pkg::STATUS_RST;
      end else begin
         status_reg <= status_next;
         if (wr_ctrl) begin
            ctrl_reg <= wdata_reg;
         end
         if (wr_mask) begin
            mask_reg <= wdata_reg;
         end
      end
   end

   // Scratch bytes, one writer per entry
   for (genvar s = 0; s < ghp_pkg::SCR_DEPTH; s++) begin : g_scr
      always_ff @(posedge ref_clk_i) begin
         if (any_rst) begin
            scr_reg[s] <= ghp_pkg::SCR_RST;
         end else if (wr_scr && wscr_idx == 2'(s)) begin
            scr_reg[s] <= wdata_reg;
         end
      end
   end

   // ******************************************************
   // Data-in and data-out registers
   // ******************************************************
   // A read of data-in frees it for the next byte
   always_ff @(posedge ref_clk_i) begin
      if (any_rst) begin
         din_reg       <= ghp_pkg::DATA_RST;
         din_full_reg  <= 1'b0;
         dout_reg      <= ghp_pkg::DATA_RST;
         dout_full_reg <= 1'b0;
      end else begin
         if (rx_take) begin
            din_reg      <= rx_data_i;
            din_full_reg <= 1'b1;
         end else if (din_read) begin
            din_full_reg <= 1'b0;
         end
         if (wr_data) begin
            dout_reg      <= wdata_reg;
            dout_full_reg <= 1'b1;
         end else if (tx_take) begin
            dout_full_reg <= 1'b0;
         end
      end
   end

   // ******************************************************
   // Interrupt, trigger and DMA request
   // ******************************************************
   // Request drops while a grant runs so one byte moves per cycle
   always_ff @(posedge ref_clk_i) begin
      if (any_rst) begin
         irq_reg       <= 1'b0;
         trig_reg      <= 1'b0;
         trig_prev_reg <= 1'b0;
         dmareq_reg    <= 1'b0;
      end else begin
         irq_reg       <= |(status_reg & mask_reg);
         trig_reg      <= trigger_cond_i | ctrl_reg[ghp_pkg::CT_FORCE_TRG];
         trig_prev_reg <= trig_reg;
         dmareq_reg    <= ctrl_reg[ghp_pkg::CT_DMA_EN] & ~granted &
                          (din_full_reg | ~dout_full_reg);
      end
   end

endmodule

// ### design/ghp_pkg.sv
package ghp_pkg;

   // ******************************************************
   // Widths and register selects
   // ******************************************************
   localparam int unsigned DATA_W       = 8;
   localparam int unsigned SEL_W        = 3;
   localparam logic [2:0]  SEL_STATUS   = 3'h0;  // Read status, write one to clear
   localparam logic [2:0]  SEL_CTRL     = 3'h1;
   localparam logic [2:0]  SEL_MASK     = 3'h2;
   localparam logic [2:0]  SEL_SCR_BASE = 3'h3;  // Selects 3 to 6 are scratch bytes
   localparam int unsigned SCR_DEPTH    = 4;
   localparam logic [2:0]  SEL_DATA     = 3'h7;

   // ******************************************************
   // Field positions, register bit 7 is the MSB
   // ******************************************************
   localparam int unsigned ST_DIN_FULL  = 7;
   localparam int unsigned ST_DOUT_FREE = 6;
   localparam int unsigned ST_TRIGGER   = 5;
   localparam int unsigned CT_DMA_EN    = 7;
   localparam int unsigned CT_IN_CHARGE = 6;
   localparam int unsigned CT_TALK      = 5;
   localparam int unsigned CT_FORCE_TRG = 4;

   // ******************************************************
   // Reset values
   // ******************************************************
   localparam logic [7:0]  STATUS_RST   = 8'h00;
   localparam logic [7:0]  CTRL_RST     = 8'h00;
   localparam logic [7:0]  MASK_RST     = 8'h00;
   localparam logic [7:0]  SCR_RST      = 8'h00;
   localparam logic [7:0]  DATA_RST     = 8'h00;

   // ******************************************************
   // Timing
   // ******************************************************
   localparam int unsigned CLK_PERIOD_NS   = 4;
   localparam int unsigned DEV_CLK_MAX_MHZ = 20;
   localparam int unsigned STROBE_NS       = 8;
   localparam int unsigned STROBE_CYCLES   =
      (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0]  STROBE_LAST     = 2'(STROBE_CYCLES - 1);

   typedef enum logic [1:0] {
      GHP_IDLE,
      GHP_SETUP,
      GHP_STROBE,
      GHP_RELEASE
   } ghp_host_state_t;

endpackage

// ### design/ghp_if.sv
`timescale 1ns/10ps
// ******************************************************
// Processor port between host and controller chip
// ******************************************************
interface ghp_if;
   logic       chip_select_n;
   logic       read_strobe;
   logic       write_strobe_n;
   logic [2:0] reg_select;
   logic       dma_grant_n;
   logic       chip_reset_n;
   logic [7:0] host_data;
   logic       host_data_oe;
   logic [7:0] dev_data;
   logic       dev_data_oe;
   logic       dma_request_n;
   logic       irq_n_oe;
   logic       trigger_out;
   logic       in_charge_n;
   logic       transceiver_direction;
   logic [7:0] cpu_data_bus;
   logic       irq_n;

   // Wire level, pull-ups give ones when nobody drives
   assign cpu_data_bus = dev_data_oe  ? dev_data  :
                         host_data_oe ? host_data : 8'hff;
   assign irq_n        = irq_n_oe ? 1'b0 : 1'b1;

   modport dev (
      input  chip_select_n, read_strobe, write_strobe_n, reg_select, dma_grant_n,
      input  chip_reset_n, cpu_data_bus,
      output dev_data, dev_data_oe, dma_request_n, irq_n_oe, trigger_out,
      output in_charge_n, transceiver_direction
   );
   modport host (
      output chip_select_n, read_strobe, write_strobe_n, reg_select, dma_grant_n,
      output chip_reset_n, host_data, host_data_oe,
      input  cpu_data_bus, dma_request_n, irq_n, trigger_out, in_charge_n,
      input  transceiver_direction
   );
endinterface

// ### design/ghp_host.sv
`timescale 1ns/10ps
module ghp_host (
   // Clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       reset_i,
   // Processor port
   ghp_if.host             port,
   // Request side
   input  wire logic       req_valid_i,
   input  wire logic       req_write_i,
   input  wire logic       req_dma_i,
   input  wire logic [2:0] req_sel_i,
   input  wire logic [7:0] req_wdata_i,
   output logic            req_ready_o,
   // Answer side
   output logic            rsp_valid_o,
   output logic [7:0]      rsp_rdata_o,
   // Chip reset and observed pins
   input  wire logic       chip_reset_i,
   output logic            irq_o,
   output logic            dma_request_o
);

   // ******************************************************
   // Declarations
   // ******************************************************
   ghp_pkg::ghp_host_state_t state_reg;
   ghp_pkg::ghp_host_state_t state_next;
   logic [1:0] cnt_reg;
   logic       write_reg;
   logic       dma_reg;
   logic [2:0] sel_reg;
   logic [7:0] wdata_reg;
   logic [7:0] wflip;
   logic [7:0] rflip;
   logic       busy;
   logic       strobing;
   logic       rd_on;
   logic       last;

   // Register bit 7 travels on bus line 0
   for (genvar i = 0; i < ghp_pkg::DATA_W; i++) begin : g_flip
      assign wflip[i] = wdata_reg[7 - i];
      assign rflip[i] = port.cpu_data_bus[7 - i];
   end

   // ******************************************************
   // Pin drive
   // ******************************************************
   // Select and data held from setup through release
   assign busy     = state_reg != ghp_pkg::GHP_IDLE;
   assign strobing = state_reg == ghp_pkg::GHP_STROBE;
   assign rd_on    = strobing & ~write_reg;
   assign last     = cnt_reg == ghp_pkg::STROBE_LAST;

   assign port.chip_select_n  = ~(busy & ~dma_reg);
   assign port.dma_grant_n    = ~(busy & dma_reg);
   assign port.reg_select     = sel_reg;
   // DMA turns the read strobe level round
   assign port.read_strobe    = (busy & dma_reg) ? ~rd_on : rd_on;
   assign port.write_strobe_n = ~(strobing & write_reg);
   assign port.host_data      = wflip;
   assign port.host_data_oe   = busy & write_reg;
   assign port.chip_reset_n   = ~chip_reset_i;
   assign req_ready_o         = ~busy;
   assign irq_o               = ~port.irq_n;
   assign dma_request_o       = ~port.dma_request_n;

   // ******************************************************
   // Sequencer
   // ******************************************************
   always_comb begin
      case (state_reg)
         ghp_pkg::GHP_IDLE:    state_next = req_valid_i ? ghp_pkg::GHP_SETUP : state_reg;
         ghp_pkg::GHP_SETUP:   state_next = ghp_pkg::GHP_STROBE;
         ghp_pkg::GHP_STROBE:  state_next = last ? ghp_pkg::GHP_RELEASE : state_reg;
         ghp_pkg::GHP_RELEASE: state_next = ghp_pkg::GHP_IDLE;
         default:              state_next = ghp_pkg::GHP_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state_reg   <= ghp_pkg::GHP_IDLE;
         cnt_reg     <= 2'h0;
         write_reg   <= 1'b0;
         dma_reg     <= 1'b0;
         sel_reg     <= 3'h0;
         wdata_reg   <= ghp_pkg::DATA_RST;
         rsp_valid_o <= 1'b0;
         rsp_rdata_o <= ghp_pkg::DATA_RST;
      end else begin
         state_reg   <= state_next;
         cnt_reg     <= strobing ? cnt_reg + 2'h1 : 2'h0;
         rsp_valid_o <= state_reg == ghp_pkg::GHP_RELEASE;
         if (!busy && req_valid_i) begin
            write_reg <= req_write_i;
            dma_reg   <= req_dma_i;
            sel_reg   <= req_dma_i ? ghp_pkg::SEL_DATA : req_sel_i;
            wdata_reg <= req_wdata_i;
         end
         // Sample at the end of the strobe, device data is registered
         if (rd_on && last) begin
            rsp_rdata_o <= rflip;
         end
      end
   end

endmodule

// ### sim/ghp_monitor.sv
`timescale 1ns/10ps
// ******************************************************
// Port checker between host and device ends
// ******************************************************
module ghp_monitor (
   // Clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       reset_i,
   // Port signals
   input  wire logic       chip_select_n,
   input  wire logic       read_strobe,
   input  wire logic       write_strobe_n,
   input  wire logic [2:0] reg_select,
   input  wire logic       dma_grant_n,
   input  wire logic       chip_reset_n,
   input  wire logic       dev_data_oe,
   input  wire logic       dma_request_n,
   input  wire logic       irq_n_oe,
   input  wire logic       irq_n,
   input  wire logic       in_charge_n,
   input  wire logic       transceiver_direction,
   input  wire logic [7:0] cpu_data_bus
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (reset_i);

   // Device drives the bus only inside a read cycle
   chk_oe_read_only: assert property (
      dev_data_oe |-> write_strobe_n && ((!chip_select_n && dma_grant_n && read_strobe)
                                         || (!dma_grant_n && !read_strobe)))
      else $error("device drove bus outside a read");
   chk_read_oe: assert property (
      write_strobe_n && !chip_select_n && dma_grant_n && read_strobe |-> dev_data_oe)
      else $error("normal read left bus undriven");
   // Grant with low read strobe is a read, whatever the select
   chk_dma_read_oe: assert property (
      write_strobe_n && !dma_grant_n && !read_strobe |-> dev_data_oe)
      else $error("dma read left bus undriven");
   chk_strobe_excl: assert property (
      !(read_strobe && !write_strobe_n && !chip_select_n))
      else $error("read and write strobes together");
   // Two cycles of reset leave request, in-charge, direction and interrupt idle
   chk_reset_idle: assert property (
      !chip_reset_n ##1 !chip_reset_n |=> dma_request_n && in_charge_n
                                          && !transceiver_direction && !irq_n_oe)
      else $error("outputs not idle after chip reset");
   // No new request while a grant is running
   chk_dma_req_grant: assert property (
      $past(dma_grant_n) == 1'b0 |-> dma_request_n)
      else $error("dma request during grant");
   chk_wstrobe_len: assert property (
      $fell(write_strobe_n) |=> !write_strobe_n ##1 write_strobe_n)
      else $error("write strobe not two cycles");
   chk_sel_hold: assert property (
      !chip_select_n && $past(chip_select_n) == 1'b0 |-> $stable(reg_select))
      else $error("select moved during access");
   chk_wdata_hold: assert property (
      !write_strobe_n |-> $stable(cpu_data_bus))
      else $error("bus data moved under write strobe");
   chk_irq_low: assert property (
      irq_n == !irq_n_oe)
      else $error("interrupt line level wrong");
endmodule

// ### sim/tb.sv
`timescale 1ns/10ps
module tb;
   // ******************************************************
   // Signals
   // ******************************************************
   logic       ref_clk_i, reset_i, req_valid, req_write, req_dma, chip_reset;
   logic       rx_valid, tx_ready, trigger_cond;
   logic [2:0] req_sel;
   logic [7:0] req_wdata, rx_data, last_rev, d, e;
   logic [7:0] scr [4];
   logic [8:0] note;
   logic       req_ready, rsp_valid, irq, dma_req, rx_ready, tx_valid;
   logic [7:0] rsp_rdata, tx_data;
   wire  [7:0] pins;
   int         n_fail, checks_done, cycles, seed, i;
   logic [8:0] exp_q [$];

   ghp_if port_if ();
   ghp_host ghp_host_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .port(port_if.host),
      .req_valid_i(req_valid), .req_write_i(req_write), .req_dma_i(req_dma),
      .req_sel_i(req_sel), .req_wdata_i(req_wdata), .req_ready_o(req_ready),
      .rsp_valid_o(rsp_valid), .rsp_rdata_o(rsp_rdata), .chip_reset_i(chip_reset),
      .irq_o(irq), .dma_request_o(dma_req));
   ghp_device ghp_device_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .port(port_if.dev),
      .rx_data_i(rx_data), .rx_valid_i(rx_valid), .rx_ready_o(rx_ready),
      .tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
      .trigger_cond_i(trigger_cond));
   ghp_monitor ghp_monitor_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
      .chip_select_n(port_if.chip_select_n), .read_strobe(port_if.read_strobe),
      .write_strobe_n(port_if.write_strobe_n), .reg_select(port_if.reg_select),
      .dma_grant_n(port_if.dma_grant_n), .chip_reset_n(port_if.chip_reset_n),
      .dev_data_oe(port_if.dev_data_oe), .dma_request_n(port_if.dma_request_n),
      .irq_n_oe(port_if.irq_n_oe), .irq_n(port_if.irq_n), .in_charge_n(port_if.in_charge_n),
      .transceiver_direction(port_if.transceiver_direction),
      .cpu_data_bus(port_if.cpu_data_bus));

   // Observed pins packed: irq dma in_charge_n dir trigger tx_valid rx_ready 0
   assign pins = {irq, dma_req, port_if.in_charge_n, port_if.transceiver_direction,
                  port_if.trigger_out, tx_valid, rx_ready, 1'b0};

   initial begin
      ref_clk_i = 1'b0;
      forever #2 ref_clk_i = ~ref_clk_i;
   end

   // ******************************************************
   // Tasks
   // ******************************************************
   task automatic compare(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", what, exp, got);
         n_fail++;
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic pause(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask

   // One host request; read expectations go into the queue
   task automatic access(input logic wr, input logic dma, input logic [2:0] sel,
                         input logic [7:0] v);
      int k;
      @(posedge ref_clk_i);
      while (req_ready !== 1'b1) @(posedge ref_clk_i);
      req_valid <= 1'b1;
      req_write <= wr;
      req_dma   <= dma;
      req_sel   <= sel;
      req_wdata <= v;
      last_rev  = {<<{v}};
      exp_q.push_back({~wr, v});
      @(posedge ref_clk_i);
      req_valid <= 1'b0;
      for (k = 0; k < 12 && exp_q.size() != 0; k++) @(posedge ref_clk_i);
   endtask

   // Only called with data-in empty, so the byte is taken at once
   task automatic send_rx(input logic [7:0] v);
      rx_data  <= v;
      rx_valid <= 1'b1;
      @(posedge ref_clk_i);
      rx_valid <= 1'b0;
   endtask

   // ******************************************************
   // Result watchers and hang guard
   // ******************************************************
   always @(posedge ref_clk_i) begin
      if (rsp_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            compare("unexpected answer", 8'h00, 8'h01);
         end else begin
            note = exp_q.pop_front();
            if (note[8]) compare("read data", note[7:0], rsp_rdata);
         end
      end
      cycles++;
      if (cycles == 6000) begin
         n_fail++;
         report_and_stop();
      end
   end

   // Wire carries the byte mirrored, line 0 as MSB
   always @(negedge ref_clk_i) begin
      if (port_if.write_strobe_n === 1'b0)
         compare("bus bit order", last_rev, port_if.cpu_data_bus);
   end

   // ******************************************************
   // Scenarios
   // ******************************************************
   initial begin
      {req_valid, req_write, req_dma, chip_reset, rx_valid, tx_ready, trigger_cond} = '0;
      {req_sel, req_wdata, rx_data, last_rev} = '0;
      seed = 89;
      reset_i = 1'b1;
      pause(12);
      reset_i <= 1'b0;
      pause(2);
      compare("pins", 8'h22, pins);
      for (i = 0; i < 7; i++) access(1'b0, 1'b0, 3'(i), 8'h00);
      $display("test reset values done");
      // Scratch bytes back to back, random data
      for (i = 0; i < 4; i++) begin
         scr[i] = 8'($random(seed));
         access(1'b1, 1'b0, 3'(i + 3), scr[i]);
      end
      for (i = 0; i < 4; i++) access(1'b0, 1'b0, 3'(i + 3), scr[i]);
      $display("test scratch done");
      access(1'b1, 1'b0, 3'h1, 8'h60);
      pause(3);
      compare("pins", 8'h12, pins);
      access(1'b1, 1'b0, 3'h1, 8'h10);
      pause(3);
      compare("pins", 8'h2a, pins);
      access(1'b0, 1'b0, 3'h0, 8'h20);
      access(1'b1, 1'b0, 3'h0, 8'h20);
      access(1'b1, 1'b0, 3'h1, 8'h00);
      pause(3);
      compare("pins", 8'h22, pins);
      trigger_cond <= 1'b1;
      pause(3);
      compare("pins", 8'h2a, pins);
      trigger_cond <= 1'b0;
      access(1'b0, 1'b0, 3'h0, 8'h20);
      access(1'b1, 1'b0, 3'h0, 8'h20);
      $display("test control pins done");
      // Masked event stays quiet until the mask opens
      d = 8'($random(seed));
      send_rx(d);
      pause(3);
      compare("pins", 8'h20, pins);
      access(1'b1, 1'b0, 3'h2, 8'h80);
      pause(3);
      compare("pins", 8'ha0, pins);
      access(1'b0, 1'b0, 3'h7, d);
      // Received flag is sticky, clear it so the line can rise again
      access(1'b1, 1'b0, 3'h0, 8'h80);
      pause(3);
      compare("pins", 8'h22, pins);
      $display("test receive and interrupt done");
      d = 8'($random(seed));
      access(1'b1, 1'b0, 3'h7, d);
      pause(2);
      compare("pins", 8'h26, pins);
      compare("tx data", d, tx_data);
      tx_ready <= 1'b1;
      pause(3);
      compare("pins", 8'h22, pins);
      access(1'b0, 1'b0, 3'h0, 8'h40);
      access(1'b1, 1'b0, 3'h0, 8'h40);
      $display("test transmit done");
      // DMA requested with select two; the host drives select seven on the pins
      tx_ready <= 1'b0;
      access(1'b1, 1'b0, 3'h1, 8'h80);
      pause(3);
      compare("pins", 8'h62, pins);
      d = 8'($random(seed));
      access(1'b1, 1'b1, 3'h2, d);
      pause(2);
      compare("pins", 8'h26, pins);
      compare("tx data", d, tx_data);
      tx_ready <= 1'b1;
      pause(3);
      compare("pins", 8'h62, pins);
      e = 8'($random(seed));
      send_rx(e);
      pause(3);
      compare("pins", 8'he0, pins);
      access(1'b0, 1'b1, 3'h3, e);
      pause(3);
      // Received flag still set and unmasked, so the interrupt stays
      compare("pins", 8'he2, pins);
      $display("test dma done");
      // Chip reset in mid-run clears control, mask and scratch
      chip_reset <= 1'b1;
      pause(3);
      chip_reset <= 1'b0;
      pause(3);
      compare("pins", 8'h22, pins);
      access(1'b0, 1'b0, 3'h2, 8'h00);
      access(1'b0, 1'b0, 3'h3, 8'h00);
      $display("test chip reset done");
      report_and_stop();
   end
endmodule
